// ---- src/vpf_defs.svh ----
// register offsets, field positions and masks of the flip control block
`ifndef VPF_DEFS_SVH
`define VPF_DEFS_SVH

// register offsets inside one engine space
`define VPF_OFF_STRM 12'h3D0
`define VPF_OFF_LUMA 12'h3D4
`define VPF_OFF_CHROMA 12'h3D8
`define VPF_OFF_TILECSC 12'h3DC
`define VPF_OFF_DST_A 12'h3EC
`define VPF_OFF_DST_B 12'h3F0
`define VPF_OFF_DPITCH 12'h3F4
`define VPF_OFF_SPITCH 12'h3F8
`define VPF_OFF_DST_C 12'h3FC

// spaces above the base, selected by address bits 13:12
`define VPF_WIN_LO 14
`define VPF_SPACE_HI 13
`define VPF_SPACE_LO 12
`define VPF_OFF_HI 11
`define VPF_SPACE_ENG0 2'h0
`define VPF_SPACE_ENG1 2'h1
`define VPF_SPACE_ALIAS 2'h2

// reset value and writable bits of each register
`define VPF_RESET_VAL 32'h00000000
`define VPF_MASK_STRM 32'hFFDE80E0
`define VPF_MASK_ADDR 32'h1FFFFFF3
`define VPF_MASK_DST_A 32'hDFFFFFF3
`define VPF_MASK_PITCH 32'h00003FF0
`define VPF_MASK_SPITCH 32'hFFFB3FF0
`define VPF_MASK_TILECSC 32'hF9F0E7FF

// field positions
`define VPF_B_XRGB 31
`define VPF_B_TILE 30
`define VPF_B_RGB888 29
`define VPF_B_LOAD 31
`define VPF_B_SJN_RST 30
`define VPF_B_FQ_EN 20
`define VPF_FQ_HI 17
`define VPF_FQ_LO 16
`define VPF_PITCH_HI 13
`define VPF_PITCH_LO 4
`define VPF_ADDR_HI 28
`define VPF_ADDR_LO 4
`define VPF_B_BUFMODE 26
`define VPF_SRC_HI 25
`define VPF_SRC_LO 24
`define VPF_B_FQ_FULL 12
`define VPF_B_SINGLE 6
`define VPF_B_SW_FLIP 4
`define VPF_B_IDLE 3
`define VPF_BUFID_LO 1
`define VPF_B_EOF 0

`endif

// ---- src/vpf_pkg.sv ----
// types shared by the flip control block
package vpf_pkg;

  // flip queue depth policy
  typedef enum logic [1:0] {
    FQ_FULL2_DROP = 2'h0,
    FQ_FULL1_DROP = 2'h1,
    FQ_FULL2_KEEP = 2'h2,
    FQ_FULL1_KEEP = 2'h3
  } vpf_fq_policy_t;

  // stream source selector
  typedef enum logic [1:0] {
    SRC_SW = 2'h0,
    SRC_RSVD = 2'h1,
    SRC_CAP0 = 2'h2,
    SRC_CAP1 = 2'h3
  } vpf_src_t;

  // output pixel packing
  typedef enum logic [1:0] {
    PACK_RGB565 = 2'h0,
    PACK_RGB888 = 2'h1,
    PACK_XRGB2101010 = 2'h2
  } vpf_pack_t;

  // per engine frame state
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } vpf_eng_state_t;

endpackage : vpf_pkg

// ---- src/vpf_flip_queue.sv ----
// two stage queue of hardware flips for one engine
`timescale 1ns/1ps
`default_nettype none
`include "vpf_defs.svh"

module vpf_flip_queue
  import vpf_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // flip events
  input wire logic push_in,
  input wire logic pop_in,
  input wire vpf_fq_policy_t policy_in,
  // state
  output logic full_out,
  output logic drop_out,
  output logic [1:0] count_out
);

  logic [1:0] cnt_r;
  logic drop_r;
  logic may_drop;

  // low policy bit lowers the full mark to one stage
  assign may_drop = (policy_in == FQ_FULL2_DROP) ||
                    (policy_in == FQ_FULL1_DROP);
  assign full_out = (cnt_r == 2'h2) ||
                    (policy_in[0] && (cnt_r != 2'h0));
  assign count_out = cnt_r;
  assign drop_out = drop_r;

  // occupancy; a flip arriving with both stages taken either drops the frame
  // in progress (the new one takes its place) or is ignored
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r <= 2'h0;
      drop_r <= 1'b0;
    end
    else
    begin
      drop_r <= 1'b0;
      if (pop_in && cnt_r != 2'h0)
      begin
        if (!push_in)
          cnt_r <= cnt_r - 2'h1;
      end
      else if (push_in)
      begin
        if (cnt_r != 2'h2)
          cnt_r <= cnt_r + 2'h1;
        else if (may_drop)
          drop_r <= 1'b1;
      end
    end
  end

  chk_queue_bound: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) cnt_r != 2'h3)
    else $error("flip queue holds more than two stages");
  chk_full_policy: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    (cnt_r == 2'h1 && !policy_in[0]) |-> !full_out)
    else $error("queue full raised early for two stage policy");
  chk_drop_frame: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    (push_in && !pop_in && cnt_r == 2'h2) |=> (drop_out == $past(may_drop)))
    else $error("drop on full queue does not follow policy");
  cov_queue_full: cover property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) cnt_r == 2'h2 && push_in);

endmodule : vpf_flip_queue
`default_nettype wire

// ---- src/vpf_top.sv ----
// destination buffer, pitch and flip control registers of two engines
`timescale 1ns/1ps
`default_nettype none
`include "vpf_defs.svh"

module vpf_top
  import vpf_pkg::*;
#(
  parameter int SJN_W = 8
)
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // host register port
  input wire logic [31:0] mmio_base_one_in,
  input wire logic mmio_req_in,
  input wire logic mmio_we_in,
  input wire logic [31:0] mmio_addr_in,
  input wire logic [31:0] mmio_wdata_in,
  output logic mmio_ack_out,
  output logic [31:0] mmio_rdata_out,
  // command regulator path
  output logic cr_req_out,
  output logic [11:0] cr_off_out,
  output logic [31:0] cr_data_out,
  input wire logic cr_wr_in,
  input wire logic [11:0] cr_off_in,
  input wire logic [31:0] cr_data_in,
  // engine events, bit 0 first engine, bit 1 second engine
  input wire logic [1:0] frame_start_in,
  input wire logic [1:0] frame_done_in,
  input wire logic [1:0] hw_flip_in,
  input wire logic [1:0] static_inc_in,
  input wire logic [1:0][10:0] pix_x_in,
  input wire logic [1:0][10:0] pix_y_in,
  // engine controls
  output logic [1:0][31:0] dst_addr_out,
  output logic [1:0][9:0] src_pitch_out,
  output logic [1:0][1:0] pack_mode_out,
  output logic [1:0] frame_req_out,
  output logic [1:0] drop_frame_out,
  output logic [1:0][2:0][24:0] fld_luma_out,
  output logic [1:0][2:0][24:0] fld_chroma_out,
  output logic [1:0][SJN_W-1:0] sjn_count_out
);

  localparam int NENG = 2;

  // write address in 16-byte units, linear or tiled
  function automatic logic [24:0] wr_addr(input logic [24:0] base,
    input logic [9:0] pitch, input logic tile,
    input logic [10:0] x, input logic [10:0] y);
    logic [24:0] step;
    logic [24:0] offs;
    if (tile)
    begin
      step = 25'(y[10:3]) * 25'({1'b0, pitch, 3'h0});
      offs = 25'({x[10:1], y[2:0], x[0]});
    end
    else
    begin
      step = 25'(y) * 25'(pitch);
      offs = 25'(x);
    end
    return base + step + offs;
  endfunction : wr_addr

  // one write strobe hitting one offset
  function automatic logic wr_to(input logic we, input logic [11:0] a,
    input logic [11:0] o);
    return we && (a == o);
  endfunction : wr_to

  // host decode
  logic [31:0] rel;
  logic hit;
  logic [1:0] space;
  logic [11:0] off;
  logic take;
  logic host_wr;

  // registers, one copy per engine
  logic [31:0] strm_r [NENG];
  logic [31:0] luma_r [NENG];
  logic [31:0] chroma_r [NENG];
  logic [31:0] tile_r [NENG];
  logic [31:0] dst_a_r [NENG];
  logic [31:0] dst_b_r [NENG];
  logic [31:0] dpitch_r [NENG];
  logic [31:0] spitch_r [NENG];
  logic [31:0] dst_c_r [NENG];
  logic [1:0] sw_flip_r;
  logic [1:0] eof_r;
  logic [1:0] bufid_r [NENG];
  vpf_eng_state_t state_r [NENG];

  // engine side write steering
  logic [1:0] eng_we;
  logic [11:0] eng_off [NENG];
  logic [31:0] eng_wd [NENG];
  logic [1:0] q_full;
  logic [1:0] q_cnt [NENG];
  logic [1:0] hw_src;
  logic rd_e;
  logic [31:0] rd_val;

  // base plus offset decode; a 16 KB window holds all three spaces
  assign rel = mmio_addr_in - mmio_base_one_in;
  assign hit = (rel[31:`VPF_WIN_LO] == '0);
  assign space = rel[`VPF_SPACE_HI:`VPF_SPACE_LO];
  assign off = rel[`VPF_OFF_HI:0];
  // a regulator write owns the cycle; the host request just waits
  assign take = mmio_req_in && !mmio_ack_out && !cr_wr_in;
  assign host_wr = take && mmio_we_in && hit;

  // regulator writes land on the first engine like direct writes
  always_comb
  begin
    eng_we[0] = cr_wr_in || (host_wr && space == `VPF_SPACE_ENG0);
    eng_off[0] = cr_wr_in ? cr_off_in : off;
    eng_wd[0] = cr_wr_in ? cr_data_in : mmio_wdata_in;
    eng_we[1] = host_wr && space == `VPF_SPACE_ENG1;
    eng_off[1] = off;
    eng_wd[1] = mmio_wdata_in;
  end

  // source is hardware whenever the field is not software
  always_comb
  begin
    for (int e = 0; e < NENG; e++)
      hw_src[e] = vpf_src_t'(strm_r[e][`VPF_SRC_HI:`VPF_SRC_LO]) != SRC_SW;
  end

  // plain configuration storage; only writable bits are kept
  always_ff @(posedge sys_clk_in)
  begin
    for (int e = 0; e < NENG; e++)
    begin
      if (!rst_n_in)
      begin
        strm_r[e] <= `VPF_RESET_VAL;
        luma_r[e] <= `VPF_RESET_VAL;
        chroma_r[e] <= `VPF_RESET_VAL;
        tile_r[e] <= `VPF_RESET_VAL;
        dst_a_r[e] <= `VPF_RESET_VAL;
        dst_b_r[e] <= `VPF_RESET_VAL;
        dpitch_r[e] <= `VPF_RESET_VAL;
        spitch_r[e] <= `VPF_RESET_VAL;
        dst_c_r[e] <= `VPF_RESET_VAL;
      end
      else
      begin
        if (wr_to(eng_we[e], eng_off[e], `VPF_OFF_STRM))
          strm_r[e] <= eng_wd[e] & `VPF_MASK_STRM;
        if (wr_to(eng_we[e], eng_off[e], `VPF_OFF_LUMA))
          luma_r[e] <= eng_wd[e] & `VPF_MASK_ADDR;
        if (wr_to(eng_we[e], eng_off[e], `VPF_OFF_CHROMA))
          chroma_r[e] <= eng_wd[e] & `VPF_MASK_ADDR;
        if (wr_to(eng_we[e], eng_off[e], `VPF_OFF_TILECSC))
          tile_r[e] <= eng_wd[e] & `VPF_MASK_TILECSC;
        if (wr_to(eng_we[e], eng_off[e], `VPF_OFF_DST_A))
          dst_a_r[e] <= eng_wd[e] & `VPF_MASK_DST_A;
        if (wr_to(eng_we[e], eng_off[e], `VPF_OFF_DST_B))
          dst_b_r[e] <= eng_wd[e] & `VPF_MASK_ADDR;
        if (wr_to(eng_we[e], eng_off[e], `VPF_OFF_DPITCH))
          dpitch_r[e] <= eng_wd[e] & `VPF_MASK_PITCH;
        if (wr_to(eng_we[e], eng_off[e], `VPF_OFF_SPITCH))
          spitch_r[e] <= eng_wd[e] & `VPF_MASK_SPITCH;
        if (wr_to(eng_we[e], eng_off[e], `VPF_OFF_DST_C))
          dst_c_r[e] <= eng_wd[e] & `VPF_MASK_ADDR;
      end
    end
  end

  // field address rotation for advanced de-interlacing
  always_ff @(posedge sys_clk_in)
  begin
    for (int e = 0; e < NENG; e++)
    begin
      if (!rst_n_in)
      begin
        fld_luma_out[e] <= '0;
        fld_chroma_out[e] <= '0;
      end
      else if (wr_to(eng_we[e], eng_off[e], `VPF_OFF_SPITCH) &&
               eng_wd[e][`VPF_B_LOAD])
      begin
        // index 0 previous, 1 current, 2 next
        fld_luma_out[e][0] <= fld_luma_out[e][1];
        fld_luma_out[e][1] <= fld_luma_out[e][2];
        fld_luma_out[e][2] <= luma_r[e][`VPF_ADDR_HI:`VPF_ADDR_LO];
        fld_chroma_out[e][0] <= fld_chroma_out[e][1];
        fld_chroma_out[e][1] <= fld_chroma_out[e][2];
        fld_chroma_out[e][2] <= chroma_r[e][`VPF_ADDR_HI:`VPF_ADDR_LO];
      end
    end
  end

  // static judgment count; the reset write beats an increment
  always_ff @(posedge sys_clk_in)
  begin
    for (int e = 0; e < NENG; e++)
    begin
      if (!rst_n_in)
        sjn_count_out[e] <= '0;
      else if (wr_to(eng_we[e], eng_off[e], `VPF_OFF_SPITCH) &&
               eng_wd[e][`VPF_B_SJN_RST])
        sjn_count_out[e] <= '0;
      else if (static_inc_in[e])
        sjn_count_out[e] <= sjn_count_out[e] + 1'b1;
    end
  end

  // software flip and end of frame flags; a set beats a clear
  always_ff @(posedge sys_clk_in)
  begin
    for (int e = 0; e < NENG; e++)
    begin
      if (!rst_n_in)
      begin
        sw_flip_r[e] <= 1'b0;
        eof_r[e] <= 1'b0;
      end
      else
      begin
        if (wr_to(eng_we[e], eng_off[e], `VPF_OFF_STRM) &&
            eng_wd[e][`VPF_B_SW_FLIP] &&
            vpf_src_t'(eng_wd[e][`VPF_SRC_HI:`VPF_SRC_LO]) == SRC_SW)
          sw_flip_r[e] <= 1'b1;
        else if (spitch_r[e][`VPF_B_FQ_EN] ? frame_start_in[e]
                                            : frame_done_in[e])
          sw_flip_r[e] <= 1'b0;
        if (frame_done_in[e])
          eof_r[e] <= 1'b1;
        else if (wr_to(eng_we[e], eng_off[e], `VPF_OFF_STRM) &&
                 eng_wd[e][`VPF_B_EOF])
          eof_r[e] <= 1'b0;
      end
    end
  end

  // frame state and destination buffer rotation
  always_ff @(posedge sys_clk_in)
  begin
    for (int e = 0; e < NENG; e++)
    begin
      if (!rst_n_in)
      begin
        state_r[e] <= ST_IDLE;
        bufid_r[e] <= 2'h0;
      end
      else
      begin
        case (state_r[e])
          ST_IDLE:
            if (frame_start_in[e])
              state_r[e] <= ST_BUSY;
          ST_BUSY:
            if (frame_done_in[e])
              state_r[e] <= ST_IDLE;
          default:
            state_r[e] <= ST_IDLE;
        endcase
        // single wins over the double or triple choice
        if (frame_done_in[e])
        begin
          if (strm_r[e][`VPF_B_SINGLE])
            bufid_r[e] <= 2'h0;
          else if (bufid_r[e] == (strm_r[e][`VPF_B_BUFMODE] ? 2'h2 : 2'h1))
            bufid_r[e] <= 2'h0;
          else
            bufid_r[e] <= bufid_r[e] + 2'h1;
        end
      end
    end
  end

  // hardware flip queues, one per engine
  for (genvar g = 0; g < NENG; g++)
  begin : g_queue
    vpf_flip_queue u_queue (
      .sys_clk_in (sys_clk_in),
      .rst_n_in (rst_n_in),
      .push_in (hw_flip_in[g] && hw_src[g]),
      .pop_in (frame_start_in[g] && hw_src[g]),
      .policy_in (vpf_fq_policy_t'(spitch_r[g][`VPF_FQ_HI:`VPF_FQ_LO])),
      .full_out (q_full[g]),
      .drop_out (drop_frame_out[g]),
      .count_out (q_cnt[g])
    );
  end

  // engine facing outputs, registered
  always_ff @(posedge sys_clk_in)
  begin
    for (int e = 0; e < NENG; e++)
    begin
      if (!rst_n_in)
      begin
        dst_addr_out[e] <= '0;
        src_pitch_out[e] <= '0;
        pack_mode_out[e] <= PACK_RGB565;
        frame_req_out[e] <= 1'b0;
      end
      else
      begin
        dst_addr_out[e] <= {3'h0, wr_addr(
          (bufid_r[e] == 2'h0) ? dst_a_r[e][`VPF_ADDR_HI:`VPF_ADDR_LO] :
          (bufid_r[e] == 2'h1) ? dst_b_r[e][`VPF_ADDR_HI:`VPF_ADDR_LO] :
                                 dst_c_r[e][`VPF_ADDR_HI:`VPF_ADDR_LO],
          dpitch_r[e][`VPF_PITCH_HI:`VPF_PITCH_LO],
          dst_a_r[e][`VPF_B_TILE], pix_x_in[e], pix_y_in[e]), 4'h0};
        src_pitch_out[e] <= spitch_r[e][`VPF_PITCH_HI:`VPF_PITCH_LO];
        // both packing bits set is illegal; the wider format wins
        if (dst_a_r[e][`VPF_B_XRGB])
          pack_mode_out[e] <= PACK_XRGB2101010;
        else if (tile_r[e][`VPF_B_RGB888])
          pack_mode_out[e] <= PACK_RGB888;
        else
          pack_mode_out[e] <= PACK_RGB565;
        frame_req_out[e] <= (state_r[e] == ST_IDLE) && !frame_start_in[e] &&
          (hw_src[e] ? (q_cnt[e] != 2'h0) : sw_flip_r[e]);
      end
    end
  end

  // read mux; alias space reads the first engine, unmapped reads zero
  always_comb
  begin
    rd_e = (space == `VPF_SPACE_ENG1);
    rd_val = `VPF_RESET_VAL;
    if (!hit || space[0] && space[1])
      rd_val = `VPF_RESET_VAL;
    else if (off == `VPF_OFF_STRM)
    begin
      rd_val = strm_r[rd_e];
      rd_val[`VPF_B_FQ_FULL] = q_full[rd_e];
      rd_val[`VPF_B_SW_FLIP] = sw_flip_r[rd_e];
      rd_val[`VPF_B_IDLE] = (state_r[rd_e] == ST_IDLE);
      rd_val[`VPF_BUFID_LO +: 2] = bufid_r[rd_e];
      rd_val[`VPF_B_EOF] = eof_r[rd_e];
    end
    else if (off == `VPF_OFF_LUMA)
      rd_val = luma_r[rd_e];
    else if (off == `VPF_OFF_CHROMA)
      rd_val = chroma_r[rd_e];
    else if (off == `VPF_OFF_TILECSC)
      rd_val = tile_r[rd_e];
    else if (off == `VPF_OFF_DST_A)
      rd_val = dst_a_r[rd_e];
    else if (off == `VPF_OFF_DST_B)
      rd_val = dst_b_r[rd_e];
    else if (off == `VPF_OFF_DPITCH)
      rd_val = dpitch_r[rd_e];
    else if (off == `VPF_OFF_SPITCH)
      rd_val = spitch_r[rd_e];
    else if (off == `VPF_OFF_DST_C)
      rd_val = dst_c_r[rd_e];
  end

  // host answer, one cycle after the request is taken
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      mmio_ack_out <= 1'b0;
      mmio_rdata_out <= `VPF_RESET_VAL;
    end
    else
    begin
      mmio_ack_out <= take;
      mmio_rdata_out <= (take && !mmio_we_in) ? rd_val : `VPF_RESET_VAL;
    end
  end

  // alias writes leave for the regulator instead of landing here
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      cr_req_out <= 1'b0;
      cr_off_out <= 12'h000;
      cr_data_out <= `VPF_RESET_VAL;
    end
    else
    begin
      cr_req_out <= host_wr && space == `VPF_SPACE_ALIAS;
      cr_off_out <= off;
      cr_data_out <= mmio_wdata_in;
    end
  end

  // reference tiled address for the first engine, buffer 0
  logic [24:0] exp_tile0;
  assign exp_tile0 = dst_a_r[0][`VPF_ADDR_HI:`VPF_ADDR_LO] +
    25'(pix_y_in[0][10:3]) * 25'({dpitch_r[0][13:4], 3'h0}) +
    25'({pix_x_in[0][10:1], pix_y_in[0][2:0], pix_x_in[0][0]});

  chk_xrgb_pack: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    dst_a_r[0][`VPF_B_XRGB] |=> pack_mode_out[0] == PACK_XRGB2101010)
    else $error("xrgb packing not selected");
  chk_tile_addr: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    (dst_a_r[0][`VPF_B_TILE] && bufid_r[0] == 2'h0)
    |=> dst_addr_out[0][28:4] == $past(exp_tile0))
    else $error("tiled write address wrong");
  chk_field_shift: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    (eng_we[0] && eng_off[0] == `VPF_OFF_SPITCH && eng_wd[0][31])
    |=> fld_luma_out[0][1] == $past(fld_luma_out[0][2]) &&
        fld_luma_out[0][2] == $past(luma_r[0][28:4]))
    else $error("field addresses did not rotate");
  chk_field_hold: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    !(eng_we[0] && eng_off[0] == `VPF_OFF_SPITCH && eng_wd[0][31])
    |=> $stable(fld_chroma_out[0]))
    else $error("field addresses changed without load");
  chk_sjn_reset: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    (eng_we[0] && eng_off[0] == `VPF_OFF_SPITCH &&
     eng_wd[0][`VPF_B_SJN_RST])
    |=> sjn_count_out[0] == '0)
    else $error("static judgment count not reset");
  chk_flip_early: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    (sw_flip_r[0] && spitch_r[0][20] && frame_start_in[0] && !eng_we[0])
    |=> !sw_flip_r[0])
    else $error("software flip not cleared at frame start");
  chk_alias_route: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    (host_wr && space == `VPF_SPACE_ALIAS)
    |=> cr_req_out && $stable(dst_a_r[0]) ##1 !cr_req_out)
    else $error("alias write not sent to regulator");
  chk_second_eng: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    (host_wr && space == `VPF_SPACE_ENG1 && off == `VPF_OFF_SPITCH)
    |=> spitch_r[1] == ($past(mmio_wdata_in) & `VPF_MASK_SPITCH))
    else $error("second engine pitch not written");
  chk_single_buf: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
    (strm_r[0][`VPF_B_SINGLE] && frame_done_in[0]) |=> bufid_r[0] == 2'h0)
    else $error("single buffer mode rotated buffers");
  chk_ack_pulse: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) take |=> mmio_ack_out ##1 !mmio_ack_out)
    else $error("host answer not a single pulse");

  cov_field_load: cover property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) eng_we[0] && eng_wd[0][31] &&
    eng_off[0] == `VPF_OFF_SPITCH);
  cov_triple_wrap: cover property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) bufid_r[0] == 2'h2 ##1 bufid_r[0] == 2'h0);
  cov_drop: cover property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) drop_frame_out[0]);

endmodule : vpf_top
`default_nettype wire

// ---- verification/vpf_reg_model.sv ----
// command regulator stand-in: replays alias writes after a fixed lag
`timescale 1ns/1ps
`default_nettype none
module vpf_reg_model
#(
  parameter int LAG = 3
)
(
  // clock
  input wire logic sys_clk_in,
  // alias write from the block
  input wire logic cr_req_in,
  input wire logic [11:0] cr_off_in,
  input wire logic [31:0] cr_data_in,
  // replayed write into the first engine
  output logic cr_wr_out,
  output logic [11:0] cr_off_out,
  output logic [31:0] cr_data_out
);
  logic [LAG-1:0][44:0] pipe_r = '0;
  logic [44:0] head_w;
  // lag shows the engine must not change before the replay lands
  always_ff @(posedge sys_clk_in)
    pipe_r <= {pipe_r[LAG-2:0], cr_req_in, cr_off_in, cr_data_in};
  // idle offset and data are inverted so stale values never look valid
  assign head_w = pipe_r[LAG-1];
  assign cr_wr_out = head_w[44];
  assign cr_off_out = cr_wr_out ? head_w[43:32] : ~head_w[43:32];
  assign cr_data_out = cr_wr_out ? head_w[31:0] : ~head_w[31:0];
endmodule : vpf_reg_model
`default_nettype wire

// ---- verification/vpf_top_tb_top.sv ----
// self-checking bench of the flip control register block
`timescale 1ns/1ps
`default_nettype none
`include "vpf_defs.svh"
module vpf_top_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [31:0] base = 32'h0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wd = 32'h0;
  logic [3:0][1:0] evt = '0;
  logic [1:0][10:0] px = '0;
  logic [1:0][10:0] py = '0;
  logic ack, cr_req, cr_wr, drop_seen;
  logic [31:0] rdata, cr_d, cr_di, q, v;
  logic [11:0] cr_o, cr_oi;
  logic [1:0][31:0] dst;
  logic [1:0][9:0] spitch;
  logic [1:0][1:0] pack;
  logic [1:0] drop, freq;
  logic [1:0][2:0][24:0] luma, chroma;
  logic [1:0][7:0] static_judgment_count;
  logic [24:0] b;
  logic [9:0] p;
  logic [10:0] x, y;
  logic [31:0] lv [4];
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  localparam logic [31:0] RA [8] = '{32'h3EC, 32'h3F0, 32'h3F4, 32'h3F8,
    32'h3FC, 32'h3E0, 32'h33F8, 32'h43F8};
  localparam logic [31:0] MK [8] = '{`VPF_MASK_DST_A, `VPF_MASK_ADDR,
    `VPF_MASK_PITCH, `VPF_MASK_SPITCH, `VPF_MASK_ADDR, 32'h0, 32'h0, 32'h0};

  vpf_top i_dut (.sys_clk_in(clk), .rst_n_in(rst_n),
    .mmio_base_one_in(base), .mmio_req_in(req), .mmio_we_in(we),
    .mmio_addr_in(addr), .mmio_wdata_in(wd), .mmio_ack_out(ack),
    .mmio_rdata_out(rdata), .cr_req_out(cr_req), .cr_off_out(cr_o),
    .cr_data_out(cr_d), .cr_wr_in(cr_wr), .cr_off_in(cr_oi),
    .cr_data_in(cr_di), .frame_start_in(evt[1]), .frame_done_in(evt[2]),
    .hw_flip_in(evt[0]), .static_inc_in(evt[3]), .pix_x_in(px),
    .pix_y_in(py), .dst_addr_out(dst), .src_pitch_out(spitch),
    .pack_mode_out(pack), .frame_req_out(freq), .drop_frame_out(drop),
    .fld_luma_out(luma), .fld_chroma_out(chroma), .sjn_count_out(static_judgment_count));
  vpf_reg_model i_reg (.sys_clk_in(clk), .cr_req_in(cr_req),
    .cr_off_in(cr_o), .cr_data_in(cr_d), .cr_wr_out(cr_wr),
    .cr_off_out(cr_oi), .cr_data_out(cr_di));

  always #5 clk = ~clk;
  // hang guard far above the few hundred cycles used
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (drop[0] === 1'b1)
      drop_seen <= 1'b1;
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // request held until ack is sampled, dropped after it, one idle cycle
  task automatic bus(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    req <= 1'b1;
    we <= w;
    addr <= base + a;
    wd <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    q = rdata;
    req <= 1'b0;
    @(posedge clk);
    if (n == 40)
      chk("ack", 32'h0, 32'h1);
  endtask : bus
  task automatic rd(input logic [31:0] a, m, e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, q & m, e);
  endtask : rd
  task automatic ev(input int k);
    evt[k] <= 2'b11;
    @(posedge clk);
    evt <= '0;
    @(posedge clk);
  endtask : ev
  function automatic logic [31:0] exp_addr(input logic [24:0] b,
    input logic [9:0] p, input logic t, input logic [10:0] x, y);
    logic [24:0] s;
    if (t)
      s = b + y[10:3] * {p, 3'b0} + {x[10:1], y[2:0], x[0]};
    else
      s = b + y * p + x;
    return {3'b0, s, 4'h0};
  endfunction : exp_addr

  initial
  begin
    void'($urandom(32'h9804E5A8));
    v = $urandom();
    base <= {v[31:14], 14'h0};
    tick(16);
    rst_n <= 1'b1;
    tick(2);
    // reset values, then masked write and read back, unmapped reads zero
    for (int i = 0; i < 8; i++)
      rd(RA[i], 32'hFFFFFFFF, 32'h0, "reset");
    for (int i = 0; i < 8; i++)
    begin
      v = $urandom();
      bus(1'b1, RA[i], v);
      rd(RA[i], 32'hFFFFFFFF, v & MK[i], "rw");
    end
    $display("test registers done");
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, `VPF_OFF_TILECSC, {2'b00, i == 1, 29'h0});
      bus(1'b1, `VPF_OFF_DST_A, {i == 2, 31'h0});
      tick(2);
      chk("pack", pack[0], i);
    end
    for (int t = 0; t < 2; t++)
    begin
      v = $urandom();
      b = v[24:0];
      p = v[31:22];
      x = $urandom_range(2047);
      y = $urandom_range(2047);
      px <= {x ^ 11'h5A5, x};
      py[0] <= y;
      bus(1'b1, `VPF_OFF_DPITCH, {18'h0, p, 4'h0});
      bus(1'b1, `VPF_OFF_DST_A, {1'b0, t == 1, 1'b0, b, 4'h0});
      tick(2);
      chk("addr", dst[0], exp_addr(b, p, t == 1, x, y));
    end
    $display("test output done");
    bus(1'b1, `VPF_OFF_SPITCH, 32'h00000150);
    bus(1'b1, 32'h1000 + `VPF_OFF_SPITCH, 32'h00000AB0);
    tick(2);
    chk("src pitch", spitch[0], 32'h15);
    chk("engine two", spitch[1], 32'hAB);
    bus(1'b1, 32'h2000 + `VPF_OFF_SPITCH, 32'h00000770);
    chk("alias early", spitch[0], 32'h15);
    tick(8);
    chk("alias", spitch[0], 32'h77);
    rd(32'h2000 + `VPF_OFF_DPITCH, 32'hFFFFFFFF, {18'h0, p, 4'h0}, "ard");
    for (int i = 0; i < 4; i++)
    begin
      lv[i] = $urandom();
      bus(1'b1, `VPF_OFF_LUMA, lv[i] & `VPF_MASK_ADDR);
      bus(1'b1, `VPF_OFF_CHROMA, (lv[i] ^ 32'h0AAAAAA0) & `VPF_MASK_ADDR);
      bus(1'b1, `VPF_OFF_SPITCH, {i < 3, 31'h0});
    end
    tick(2);
    for (int k = 0; k < 3; k++)
    begin
      chk("field", luma[0][k], lv[k][28:4]);
      chk("chroma", chroma[0][k], lv[k][28:4] ^ 25'h0AAAAAA);
    end
    repeat (3) ev(3);
    chk("sjn", static_judgment_count[0], 32'h3);
    bus(1'b1, `VPF_OFF_SPITCH, 32'h40000000);
    tick(2);
    chk("sjn clear", static_judgment_count[0], 32'h0);
    $display("test fields done");
    // capture source, every queue policy: fill, overflow, drain
    bus(1'b1, `VPF_OFF_STRM, 32'h02000000);
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, `VPF_OFF_SPITCH, m << 16);
      ev(0);
      rd(`VPF_OFF_STRM, 32'h1000, {m[0], 12'h0}, "full one");
      ev(0);
      rd(`VPF_OFF_STRM, 32'h1000, 32'h1000, "full two");
      drop_seen <= 1'b0;
      ev(0);
      tick(3);
      chk("drop", drop_seen, m < 2);
      ev(1);
      ev(1);
      rd(`VPF_OFF_STRM, 32'h1000, 32'h0, "empty");
    end
    $display("test queue done");
    for (int f = 0; f < 2; f++)
    begin
      bus(1'b1, `VPF_OFF_SPITCH, {11'h0, f == 1, 20'h0});
      // second pass picks single buffer; bit 0 clears end of frame
      bus(1'b1, `VPF_OFF_STRM, {25'h0, f == 1, 6'h11});
      // the queue pass left the engine busy, so only the second asks
      chk("frame req", freq[0], f == 1);
      ev(1);
      rd(`VPF_OFF_STRM, 32'h11, {27'h0, f == 0, 4'h0}, "sw flip");
      ev(2);
      rd(`VPF_OFF_STRM, 32'h1F, f == 0 ? 32'hB : 32'h9, "done");
    end
    $display("test flip done");
    end_sim();
  end
endmodule : vpf_top_tb_top
`default_nettype wire
